// ===== src/dmc_pkg.sv
package dmc_pkg;

    // ------------------------------------------------------------------
    // Register map (indices; byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS = 8'h30;
    localparam logic [7:0] IDX_MODE = 8'h31;
    localparam logic [7:0] IDX_CH0_COUNT = 8'h26;
    localparam logic [7:0] IDX_CH1_COUNT = 8'h2E;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int ST_CH1_RUN = 7;
    localparam int ST_CH0_RUN = 6;
    localparam int ST_CH1_GATE = 5;
    localparam int ST_CH0_GATE = 4;
    localparam int ST_CH1_IRQ = 3;
    localparam int ST_CH0_IRQ = 2;
    localparam int ST_MASTER = 0;

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int MD_DEST_HI = 5;
    localparam int MD_DEST_LO = 4;
    localparam int MD_SRC_HI = 3;
    localparam int MD_SRC_LO = 2;
    localparam int MD_TIMING = 1;
    localparam logic [1:0] SEL_IO_FIXED = 2'h3;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Timing and bus answers
    // ------------------------------------------------------------------
    localparam int XFER_CYCLES = 6;
    localparam int COUNT_W = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Address mode of one side of a channel 0 transfer
    typedef enum logic [1:0]
    {
        DMC_MEM_INC = 2'h0,
        DMC_MEM_DEC = 2'h1,
        DMC_MEM_FIX = 2'h2,
        DMC_IO_FIX = 2'h3
    } dmc_sel_t;

    // Channel 0 mode settings as a carrier
    typedef struct packed
    {
        dmc_sel_t dest;
        dmc_sel_t src;
        logic burst;
    } dmc_mode_t;

endpackage

// ===== src/dmc_byte_counter.sv
`timescale 1ns/1ps
module dmc_byte_counter #(
    parameter int WIDTH = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    input wire logic dec,
    output logic [WIDTH-1:0] count,
    output logic zero,
    output logic last
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (WIDTH < 2 || WIDTH > 32)
    begin : g_bad_width
        $error("dmc_byte_counter: WIDTH must be 2 to 32");
    end

    logic [WIDTH-1:0] count_reg;

    // Load from software, else count one byte down per transfer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_reg <= '0;
        else if (load)
            count_reg <= load_val;
        else if (dec && count_reg != '0)
            count_reg <= count_reg - WIDTH'(1);
    end

    // Status views of the count
    assign count = count_reg;
    assign zero = (count_reg == '0);
    assign last = (count_reg == WIDTH'(1));

endmodule

// ===== src/dmc_ch0_pacer.sv
`timescale 1ns/1ps
module dmc_ch0_pacer
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic run,
    input wire dmc_pkg::dmc_mode_t mode,
    input wire logic ext_request,
    input wire logic count_zero,
    output logic step,
    output logic hold
);

    logic mem_to_mem;
    logic blocked;
    logic give_back_reg;

    // Reserved pairs (both sides fixed memory or I/O) never run
    assign blocked = mode.dest[1] && mode.src[1];
    assign mem_to_mem = (mode.dest != dmc_pkg::DMC_IO_FIX) &&
                        (mode.src != dmc_pkg::DMC_IO_FIX);

    // Memory pairs pace themselves; I/O pairs wait for the request pin
    always_comb
    begin
        step = 1'b0;
        if (tick && run && !count_zero && !blocked)
        begin
            if (mem_to_mem)
                step = !give_back_reg;
            else
                step = ext_request;
        end
    end

    // Burst holds the bus throughout; cycle steal frees one slot per byte
    assign hold = run && !count_zero && !blocked &&
                  (mem_to_mem ? !give_back_reg : step);

    // Cycle steal: a byte is followed by one transfer slot for the CPU
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            give_back_reg <= 1'b0;
        else if (step && !mode.burst && mem_to_mem)
            give_back_reg <= 1'b1;
        else if (tick)
            give_back_reg <= 1'b0;
    end

endmodule

// ===== src/dmc_dma_ctrl.sv
// Function
// - Channel 0 runs only with own and master enable
// - Channel 1 runs only with own and master enable
// - Channel 0 count reaching zero clears its enable
// - Channel 0 off with irq enable raises request
// - Channel 0 enable written only with gate zero
// - Channel 1 enable written only with gate zero
// - Gate bits store nothing, always read one
// - Writing channel 0 enable one sets master
// - Writing channel 0 enable zero stops channel
// - Reset clears channel 0 enable
// - Channel 1 irq enable gates its request
// - Channel 0 irq enable gates its request
// - Non-maskable interrupt clears master enable
// - Master ignores writes; channel enable write resumes
// - Reset clears master enable
// - Bits 5:4 select channel 0 destination mode
// - Write-only bits 3:2 select source mode
// - Mode codes fixed; pairs with both sides fixed memory or I/O reserved
// - Memory pairs self-paced, bit 1 picks timing
// - Burst holds bus until count is zero
// - Cycle steal returns one cycle per byte
// - I/O pairs paced by request pin
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module dmc_dma_ctrl #(
    parameter int COUNT_W = dmc_pkg::COUNT_W
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dmc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dmc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic nmi,
    input wire logic ch0_ext_request,
    input wire logic ch1_ext_request,
    output logic dma_irq,
    output logic ch0_bus_hold,
    output logic ch0_xfer,
    output logic ch1_xfer
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (COUNT_W < 2 || COUNT_W > 32)
    begin : g_bad_count
        $error("dmc_dma_ctrl: COUNT_W must be 2 to 32");
    end

    // Word index of a byte address
    function automatic logic [7:0] word_idx(
        input logic [dmc_pkg::ADDR_W-1:0] a);
        word_idx = a[9:2];
    endfunction

    logic aw_held_reg;
    logic w_held_reg;
    logic [dmc_pkg::ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic wr_status;
    logic wr_mode;
    logic wr_cnt0;
    logic wr_cnt1;
    logic wr_hit;
    logic ch0_run_enable;
    logic ch1_run_enable;
    logic ch0_end_irq_enable;
    logic ch1_end_irq_enable;
    logic master_dma_enable;
    logic nmi_prev_reg;
    logic nmi_edge;
    logic ch0_sw_write;
    logic ch1_sw_write;
    dmc_pkg::dmc_mode_t mode_reg;
    logic [7:0] status_view;
    logic [7:0] mode_view;
    logic [2:0] tick_cnt_reg;
    logic tick;
    logic step0;
    logic step1;
    logic hold0;
    logic zero0;
    logic zero1;
    logic last0;
    logic last1;
    logic done0;
    logic done1;
    logic [COUNT_W-1:0] count0;
    logic [COUNT_W-1:0] count1;

    // ------------------------------------------------------------------
    // Bus slave: write path
    // ------------------------------------------------------------------

    // Address and data are caught in either order, then applied together
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end
        else if (do_write)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid && aresetn;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid && aresetn;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // Decode of the applied write; status and mode need byte lane 0, counts ignore the strobes
    assign wr_status = do_write && wstrb_reg[0] &&
                       word_idx(awaddr_reg) == dmc_pkg::IDX_STATUS;
    assign wr_mode = do_write && wstrb_reg[0] &&
                     word_idx(awaddr_reg) == dmc_pkg::IDX_MODE;
    assign wr_cnt0 = do_write && word_idx(awaddr_reg) ==
                     dmc_pkg::IDX_CH0_COUNT;
    assign wr_cnt1 = do_write && word_idx(awaddr_reg) ==
                     dmc_pkg::IDX_CH1_COUNT;
    assign wr_hit = awaddr_reg[dmc_pkg::ADDR_W-1:10] == '0 &&
                    (word_idx(awaddr_reg) == dmc_pkg::IDX_STATUS ||
                     word_idx(awaddr_reg) == dmc_pkg::IDX_MODE ||
                     word_idx(awaddr_reg) == dmc_pkg::IDX_CH0_COUNT ||
                     word_idx(awaddr_reg) == dmc_pkg::IDX_CH1_COUNT);

    // Write response, error for an unmapped address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dmc_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Enable, gate and interrupt-enable bits
    // ------------------------------------------------------------------

    // Software changes a channel enable only when its gate bit is written as zero
    assign ch0_sw_write = wr_status && !wdata_reg[dmc_pkg::ST_CH0_GATE];
    assign ch1_sw_write = wr_status && !wdata_reg[dmc_pkg::ST_CH1_GATE];
    assign nmi_edge = nmi && !nmi_prev_reg;

    // Channel enables: software write wins over end of count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch0_run_enable <= 1'b0;
            ch1_run_enable <= 1'b0;
        end
        else
        begin
            if (ch0_sw_write)
                ch0_run_enable <= wdata_reg[dmc_pkg::ST_CH0_RUN];
            else if (done0)
                ch0_run_enable <= 1'b0;
            if (ch1_sw_write)
                ch1_run_enable <= wdata_reg[dmc_pkg::ST_CH1_RUN];
            else if (done1)
                ch1_run_enable <= 1'b0;
        end
    end

    // Master enable: cleared by NMI, set only through a channel enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            master_dma_enable <= 1'b0;
            nmi_prev_reg <= 1'b0;
        end
        else
        begin
            nmi_prev_reg <= nmi;
            if (nmi_edge)
                master_dma_enable <= 1'b0;
            else if ((ch0_sw_write && wdata_reg[dmc_pkg::ST_CH0_RUN]) ||
                     (ch1_sw_write && wdata_reg[dmc_pkg::ST_CH1_RUN]))
                master_dma_enable <= 1'b1;
        end
    end

    // Termination interrupt enables and channel 0 mode fields
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch0_end_irq_enable <= 1'b0;
            ch1_end_irq_enable <= 1'b0;
            mode_reg <= dmc_pkg::dmc_mode_t'(5'h00);
        end
        else
        begin
            if (wr_status)
            begin
                ch0_end_irq_enable <= wdata_reg[dmc_pkg::ST_CH0_IRQ];
                ch1_end_irq_enable <= wdata_reg[dmc_pkg::ST_CH1_IRQ];
            end
            if (wr_mode)
            begin
                mode_reg.dest <= dmc_pkg::dmc_sel_t'(
                    wdata_reg[dmc_pkg::MD_DEST_HI:dmc_pkg::MD_DEST_LO]);
                mode_reg.src <= dmc_pkg::dmc_sel_t'(
                    wdata_reg[dmc_pkg::MD_SRC_HI:dmc_pkg::MD_SRC_LO]);
                mode_reg.burst <= wdata_reg[dmc_pkg::MD_TIMING];
            end
        end
    end

    // Interrupt request is a level: channel stopped and its enable set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dma_irq <= 1'b0;
        else
            dma_irq <= (!ch0_run_enable && ch0_end_irq_enable) ||
                       (!ch1_run_enable && ch1_end_irq_enable);
    end

    // ------------------------------------------------------------------
    // Bus slave: read path
    // ------------------------------------------------------------------

    // Gate bits always read one; source field does not read back
    assign status_view = {ch1_run_enable, ch0_run_enable, 2'h3,
                          ch1_end_irq_enable, ch0_end_irq_enable, 1'b0,
                          master_dma_enable};
    assign mode_view = {2'h0, mode_reg.dest, 2'h0, mode_reg.burst, 1'b0};

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= dmc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= dmc_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[dmc_pkg::ADDR_W-1:10] != '0)
                s_axi_rresp <= dmc_pkg::RESP_SLVERR;
            else if (word_idx(s_axi_araddr) == dmc_pkg::IDX_STATUS)
                s_axi_rdata <= {24'h000000, status_view};
            else if (word_idx(s_axi_araddr) == dmc_pkg::IDX_MODE)
                s_axi_rdata <= {24'h000000, mode_view};
            else if (word_idx(s_axi_araddr) == dmc_pkg::IDX_CH0_COUNT)
                s_axi_rdata <= 32'(count0);
            else if (word_idx(s_axi_araddr) == dmc_pkg::IDX_CH1_COUNT)
                s_axi_rdata <= 32'(count1);
            else
                s_axi_rresp <= dmc_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    assign s_axi_arready = !s_axi_rvalid && aresetn;

    // ------------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------------

    // One transfer slot every few clocks
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tick_cnt_reg <= 3'h0;
        else if (tick)
            tick_cnt_reg <= 3'h0;
        else
            tick_cnt_reg <= tick_cnt_reg + 3'h1;
    end

    assign tick = (tick_cnt_reg == 3'(dmc_pkg::XFER_CYCLES - 1));

    // Channel 0 pacing, gated by both enables
    dmc_ch0_pacer u_pacer
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .run(ch0_run_enable && master_dma_enable),
        .mode(mode_reg),
        .ext_request(ch0_ext_request),
        .count_zero(zero0),
        .step(step0),
        .hold(hold0)
    );

    // Channel 1 uses slots that channel 0 leaves free
    assign step1 = tick && ch1_run_enable && master_dma_enable &&
                   ch1_ext_request && !zero1 && !step0;
    assign done0 = step0 && last0;
    assign done1 = step1 && last1;

    dmc_byte_counter #(.WIDTH(COUNT_W)) u_cnt0
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(wr_cnt0),
        .load_val(wdata_reg[COUNT_W-1:0]),
        .dec(step0),
        .count(count0),
        .zero(zero0),
        .last(last0)
    );

    dmc_byte_counter #(.WIDTH(COUNT_W)) u_cnt1
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(wr_cnt1),
        .load_val(wdata_reg[COUNT_W-1:0]),
        .dec(step1),
        .count(count1),
        .zero(zero1),
        .last(last1)
    );

    // Registered transfer strobes and bus hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch0_xfer <= 1'b0;
            ch1_xfer <= 1'b0;
            ch0_bus_hold <= 1'b0;
        end
        else
        begin
            ch0_xfer <= step0;
            ch1_xfer <= step1;
            ch0_bus_hold <= hold0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ch0_quiet;
        !step0 [*8];
    endsequence

    a_ch0_run_gate: assert property (step0 |-> ch0_run_enable && master_dma_enable)
        else $error("channel 0 moved while disabled");
    a_ch1_run_gate: assert property (step1 |-> ch1_run_enable && master_dma_enable)
        else $error("channel 1 moved while disabled");
    a_ch0_end_clear: assert property (done0 && !ch0_sw_write |=> !ch0_run_enable)
        else $error("channel 0 enable not cleared at end");
    a_irq_level: assert property (!ch0_run_enable && ch0_end_irq_enable |=> dma_irq)
        else $error("channel 0 end request missing");
    a_gate_blocks: assert property (wr_status && wdata_reg[dmc_pkg::ST_CH0_GATE] && !done0 |=> $stable(ch0_run_enable))
        else $error("channel 0 enable changed with gate set");
    a_gate_reads_one: assert property (s_axi_rvalid && $rose(s_axi_rvalid) && s_axi_rresp == dmc_pkg::RESP_OKAY && $past(word_idx(s_axi_araddr)) == dmc_pkg::IDX_STATUS |-> s_axi_rdata[5:4] == 2'h3)
        else $error("gate bits did not read one");
    a_de_sets_main: assert property (ch0_sw_write && wdata_reg[dmc_pkg::ST_CH0_RUN] && !nmi_edge |=> master_dma_enable && ch0_run_enable)
        else $error("channel 0 enable write did not set master");
    a_nmi_clears: assert property (nmi_edge |=> !master_dma_enable ##1 !step0)
        else $error("NMI did not clear master enable");
    a_burst_hold: assert property (step0 && mode_reg.burst && !last0 && mode_reg.dest != dmc_pkg::DMC_IO_FIX && mode_reg.src != dmc_pkg::DMC_IO_FIX |-> ##6 (step0 || !(ch0_run_enable && master_dma_enable) || $past(wr_mode)))
        else $error("burst transfer paused");
    a_steal_gap: assert property (step0 && !mode_reg.burst && mode_reg.dest != dmc_pkg::DMC_IO_FIX && mode_reg.src != dmc_pkg::DMC_IO_FIX |=> s_ch0_quiet)
        else $error("cycle steal skipped the CPU slot");

endmodule

// ===== verification/dmc_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Far side: peripheral request pins and the CPU's non-maskable interrupt
// ----------------------------------------------------------------------
module dmc_far_model
(
    input wire logic [1:0] req_on,
    input wire logic nmi_fire,
    output logic ch0_ext_request,
    output logic ch1_ext_request,
    output logic nmi
);
    // Requests are levels held for as long as the peripheral wants bytes
    assign ch0_ext_request = req_on[0];
    assign ch1_ext_request = req_on[1];
    // Interrupt pulse; its rising edge is what the block reacts to
    assign nmi = nmi_fire;
endmodule

// ===== verification/test_dma_enable_and_ch0_mode_ctrl.sv
`timescale 1ns/1ps
module test_dma_enable_and_ch0_mode_ctrl;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic [11:0] AST = {2'h0, dmc_pkg::IDX_STATUS, 2'h0};
    localparam logic [11:0] AMD = {2'h0, dmc_pkg::IDX_MODE, 2'h0};
    localparam logic [11:0] AC0 = {2'h0, dmc_pkg::IDX_CH0_COUNT, 2'h0};
    localparam logic [11:0] AC1 = {2'h0, dmc_pkg::IDX_CH1_COUNT, 2'h0};
    localparam logic [1:0] OK = dmc_pkg::RESP_OKAY;
    localparam logic [1:0] ER = dmc_pkg::RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, nmi_fire = 1'b0;
    logic [1:0] req_on = 2'h0;
    logic [7:0] lf = 8'h1F;
    logic awready, wready, bvalid, arready, rvalid, irq, hold, x0, x1;
    logic req0, req1, nmi, hold1st;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] rq[$], bq[$];
    int err_total = 0, samples_checked = 0;
    int n0 = 0, n1 = 0, gap = 0, lastt = 0, cyc = 0;

    dmc_dma_ctrl dut_u
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .nmi(nmi), .ch0_ext_request(req0),
        .ch1_ext_request(req1), .dma_irq(irq), .ch0_bus_hold(hold),
        .ch0_xfer(x0), .ch1_xfer(x1)
    );
    dmc_far_model far_u
    (
        .req_on(req_on), .nmi_fire(nmi_fire), .ch0_ext_request(req0),
        .ch1_ext_request(req1), .nmi(nmi)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    always #12.5 aclk = ~aclk;

    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic end_of_test(input bit tmo);
        if (tmo)
            err_total++;
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chkn(input int g, input int e);
        chk(34'(g), 34'(e));
    endtask

    task automatic cw(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] e);
        int n;
        n = 0;
        bq.push_back({32'h0, e});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 60);
        if (n >= 60)
            end_of_test(1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 60);
        if (n >= 60)
            end_of_test(1);
    endtask

    task automatic wirq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(posedge aclk);
            n++;
        end
        if (n >= 400)
            end_of_test(1);
        // Let the monitor's counters settle past the last byte pulse
        cw(2);
    endtask

    // Monitor: answers against the oldest note, byte pulses counted
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (rvalid === 1'b1)
            chk({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'b1)
            chk({32'h0, bresp}, bq.pop_front());
        if (x0 === 1'b1)
        begin
            if (n0 == 0)
                hold1st <= hold;
            gap <= cyc - lastt;
            lastt <= cyc;
            n0 <= n0 + 1;
        end
        if (x1 === 1'b1)
            n1 <= n1 + 1;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int c, b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(AST, {OK, 32'h30});
        rd(AMD, {OK, 32'h00});
        rd(12'h400, {ER, 32'h00});
        wr(12'h400, 32'h0, ER);
        wr(AST, 32'hF9, OK);
        rd(AST, {OK, 32'h38});
        cw(2);
        chk({33'h0, irq}, 34'h1);
        wr(AST, 32'h30, OK);
        cw(2);
        chk({33'h0, irq}, 34'h0);
        for (int t = 1; t >= 0; t--)
        begin
            lf = nx(lf);
            c = 2 + lf % 3;
            b0 = n0;
            wr(AC0, 32'(c), OK);
            wr(AMD, 32'(t * 2), OK);
            wr(AST, 32'h64, OK);
            cw(1);
            chk({33'h0, irq}, 34'h0);
            wirq;
            chkn(n0 - b0, c);
            chkn(gap, t ? 6 : 12);
            rd(AST, {OK, 32'h35});
            rd(AC0, {OK, 32'h00});
        end
        chk({33'h0, hold1st}, 34'h1);
        wr(AC0, 32'h100, OK);
        wr(AMD, 32'h32, OK);
        wr(AST, 32'h60, OK);
        b0 = n0;
        cw(30);
        chkn(n0 - b0, 0);
        req_on <= 2'h3;
        cw(30);
        chkn(32'(n0 > b0), 1);
        nmi_fire <= 1'b1;
        @(posedge aclk);
        nmi_fire <= 1'b0;
        cw(3);
        b0 = n0;
        rd(AST, {OK, 32'h70});
        cw(30);
        chkn(n0 - b0, 0);
        wr(AST, 32'h60, OK);
        rd(AST, {OK, 32'h71});
        wr(AST, 32'h20, OK);
        cw(3);
        b0 = n0;
        cw(30);
        chkn(n0 - b0, 0);
        rd(AST, {OK, 32'h31});
        wr(AC0, 32'h2, OK);
        wr(AMD, 32'h28, OK);
        wr(AST, 32'h60, OK);
        cw(30);
        chkn(n0 - b0, 0);
        b0 = n1;
        wr(AC1, 32'h2, OK);
        wr(AST, 32'h98, OK);
        wirq;
        chkn(n1 - b0, 2);
        rd(AST, {OK, 32'h79});
        wr(AMD, 32'h3E, OK);
        rd(AMD, {OK, 32'h32});
        end_of_test(0);
    end
endmodule
